// File: verilog/arc_pkg.sv
`default_nettype none
package arc_pkg;
   // register byte offsets
   localparam logic [7:0] ARC_CTRL_OFS = 8'h00;
   localparam logic [7:0] ARC_STAT_OFS = 8'h04;
   localparam logic [7:0] ARC_CNT_OFS = 8'h08;
   localparam logic [7:0] ARC_CHCFG_OFS = 8'h10;
   // control register fields
   localparam int ARC_CTRL_MODE_LSB = 0;
   localparam int ARC_CTRL_FIXCAL_BIT = 2;
   localparam int ARC_CTRL_DETECT_BIT = 3;
   localparam int ARC_CTRL_RUN_BIT = 4;
   localparam int ARC_CTRL_LAST_LSB = 8;
   // status register fields
   localparam int ARC_STAT_EXTERNAL_CRYSTAL_BIT = 0;
   localparam int ARC_STAT_OSC_BIT = 1;
   localparam int ARC_STAT_CH_LSB = 4;
   localparam int ARC_STAT_OFSRUN_LSB = 8;
   localparam int ARC_STAT_GNRUN_LSB = 12;
   // converter clock divisors and correction overhead (converter clocks)
   localparam logic [23:0] ARC_SLOW_DIV = 24'h041000;
   localparam logic [23:0] ARC_FAST_DIV = 24'h004100;
   localparam logic [23:0] ARC_CAL_EXTRA = 24'h001040;
   localparam logic [23:0] ARC_OFS_EXTRA = 24'h000000;
   // reset values and gain and rate thresholds
   localparam logic [2:0] ARC_RATE_RST = 3'h7;
   localparam logic [2:0] ARC_GAIN_RST = 3'h0;
   localparam logic [2:0] ARC_GAIN_FIXED_MIN = 3'h4;
   localparam logic [2:0] ARC_RATE_MAINS_MAX = 3'h3;

   typedef enum logic [1:0] {
      BG_CAL_OFF = 2'b00,
      OFFSET_CORRECT_GAIN_ESTIMATE = 2'b01,
      OFFSET_GAIN_CORRECT = 2'b10,
      OFFSET_GAIN_ESTIMATE = 2'b11
   } arc_bgmode_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } arc_state_t;

   // channel_config_reg layout
   typedef struct packed {
      logic buf_en;
      logic [2:0] gain;
      logic rsvd;
      logic [2:0] rate;
   } arc_chcfg_t;

   typedef struct packed {
      logic fixed_stage_on;
      logic [1:0] pga_code;
      logic input_buffer_on;
   } arc_path_t;
endpackage : arc_pkg
`default_nettype wire

// File: verilog/arc_rate_gain_ctrl.sv
`default_nettype none
module arc_rate_gain_ctrl
   import arc_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter logic [23:0] SLOW_DIV = ARC_SLOW_DIV,
   parameter logic [23:0] FAST_DIV = ARC_FAST_DIV,
   parameter logic [23:0] CAL_EXTRA = ARC_CAL_EXTRA,
   parameter logic [23:0] OFS_EXTRA = ARC_OFS_EXTRA
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // converter clock and oscillator
   input wire logic i_mod_clk_tick,
   input wire logic i_external_crystal_present,
   output logic o_int_osc_en,
   output logic o_ext_clk_sel,
   // channel of the last completed conversion, signal path of the channel under conversion
   output logic [1:0] o_active_ch,
   output logic o_fixed_stage_on,
   output logic [1:0] o_pga_code,
   output logic o_input_buffer_on,
   output logic o_mains_reject,
   // background calibration control
   output logic o_offset_measure,
   output logic o_gain_measure,
   output logic o_offset_from_run,
   output logic o_gain_from_run,
   // conversion result strobe
   output logic o_conv_done,
   output logic [1:0] o_done_ch
);
   localparam logic [1:0] CH_MAX = 2'(NUM_CH - 1);

   function automatic logic [23:0] arc_period(input logic [2:0] rate, input logic [1:0] mode,
                                              input logic fixcal);
      logic [23:0] base;
      logic [23:0] extra;
      base = rate[2] ? FAST_DIV : SLOW_DIV;
      extra = 24'h000000;
      if (mode == OFFSET_GAIN_CORRECT && !fixcal) begin
         extra = CAL_EXTRA;
      end else if (mode == OFFSET_GAIN_CORRECT || mode == OFFSET_CORRECT_GAIN_ESTIMATE) begin
         extra = OFS_EXTRA;
      end
      return 24'(base << (2'h3 - rate[1:0])) + extra;
   endfunction : arc_period

   function automatic arc_path_t arc_path(input arc_chcfg_t cfg);
      arc_path_t p;
      p.fixed_stage_on = (cfg.gain >= ARC_GAIN_FIXED_MIN);
      p.pga_code = cfg.gain[1:0];
      p.input_buffer_on = (cfg.gain >= ARC_GAIN_FIXED_MIN) | cfg.buf_en;
      return p;
   endfunction : arc_path

   // registers
   arc_chcfg_t cfg_ff [NUM_CH];
   arc_bgmode_t mode_ff;
   logic fixcal_ff;
   logic detect_ff;
   logic run_ff;
   logic [1:0] last_ch_ff;
   arc_state_t state_ff;
   logic [1:0] ch_ff;
   logic [23:0] cnt_ff;
   logic [15:0] result_cnt_ff;
   logic [NUM_CH-1:0] ofs_run_ff;
   logic [NUM_CH-1:0] gain_run_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   arc_path_t path_ff;
   logic int_osc_ff;
   logic ext_sel_ff;
   logic mains_ff;
   logic ofs_meas_ff;
   logic gain_meas_ff;
   logic ofs_src_ff;
   logic gain_src_ff;
   logic done_ff;
   logic [1:0] done_ch_ff;

   // bus decode
   wire logic setup = i_psel & ~i_penable;
   wire logic commit = i_psel & i_penable & pready_ff;
   wire logic wr_ctrl = commit & i_pwrite & (i_paddr == ARC_CTRL_OFS);
   wire logic wr_cnt = commit & i_pwrite & (i_paddr == ARC_CNT_OFS);
   wire logic [7:0] ch_ofs = i_paddr - ARC_CHCFG_OFS;
   wire logic is_ch = (i_paddr >= ARC_CHCFG_OFS) && (ch_ofs[7:2] < 6'(NUM_CH))
                      && (i_paddr[1:0] == 2'h0);
   wire logic [1:0] ch_idx = ch_ofs[3:2];
   wire logic mapped = is_ch || (i_paddr == ARC_CTRL_OFS) || (i_paddr == ARC_STAT_OFS)
                       || (i_paddr == ARC_CNT_OFS);
   wire logic wr_ch = commit & i_pwrite & is_ch;

   // conversion sequencing
   wire logic [1:0] last_eff = (last_ch_ff > CH_MAX) ? CH_MAX : last_ch_ff;
   wire arc_chcfg_t cur_cfg = cfg_ff[ch_ff];
   wire logic [23:0] cur_period = arc_period(cur_cfg.rate, mode_ff, fixcal_ff);
   wire logic conv_end = (state_ff == ST_CONV) & i_mod_clk_tick
                         & (cnt_ff >= cur_period - 24'h000001); // no stall on shorter rate
   wire logic [1:0] ch_next = (ch_ff >= last_eff) ? 2'h0 : ch_ff + 2'h1;
   wire logic ofs_corr = (mode_ff == OFFSET_CORRECT_GAIN_ESTIMATE)
                         | (mode_ff == OFFSET_GAIN_CORRECT);
   wire logic gain_corr = (mode_ff == OFFSET_GAIN_CORRECT);
   wire logic external_crystal_use = detect_ff & i_external_crystal_present;
   wire arc_path_t nxt_path = arc_path(cur_cfg);

   wire logic [31:0] stat_word = {16'h0000, 4'(gain_run_ff), 4'(ofs_run_ff),
                                  2'h0, ch_ff, 2'h0, ~external_crystal_use, external_crystal_use};
   wire logic [31:0] ctrl_word = {22'h000000, last_ch_ff, 3'h0, run_ff, detect_ff,
                                  fixcal_ff, mode_ff};
   wire logic [31:0] rd_word = is_ch ? {24'h000000, cfg_ff[ch_idx]} :
                               (i_paddr == ARC_CTRL_OFS) ? ctrl_word :
                               (i_paddr == ARC_STAT_OFS) ? stat_word :
                               (i_paddr == ARC_CNT_OFS) ? {16'h0000, result_cnt_ff} :
                               32'h00000000;

   // apb: one wait state, registered answer
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= i_psel & i_penable & ~pready_ff;
         pslverr_ff <= i_psel & i_penable & ~pready_ff & ~mapped;
         if (setup) begin
            prdata_ff <= i_pwrite ? 32'h00000000 : rd_word;
         end
      end
   end

   // per-channel gain, buffer and rate settings
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < NUM_CH; i++) begin
            cfg_ff[i] <= '{buf_en: 1'b0, gain: ARC_GAIN_RST, rsvd: 1'b0, rate: ARC_RATE_RST};
         end
      end else if (wr_ch) begin
         cfg_ff[ch_idx] <= '{buf_en: i_pwdata[7], gain: i_pwdata[6:4], rsvd: 1'b0,
                            rate: i_pwdata[2:0]};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         mode_ff <= BG_CAL_OFF;
         fixcal_ff <= 1'b0;
         detect_ff <= 1'b0;
         run_ff <= 1'b0;
         last_ch_ff <= 2'h0;
      end else if (wr_ctrl) begin
         mode_ff <= arc_bgmode_t'(i_pwdata[ARC_CTRL_MODE_LSB +: 2]);
         fixcal_ff <= i_pwdata[ARC_CTRL_FIXCAL_BIT];
         detect_ff <= i_pwdata[ARC_CTRL_DETECT_BIT];
         run_ff <= i_pwdata[ARC_CTRL_RUN_BIT];
         last_ch_ff <= i_pwdata[ARC_CTRL_LAST_LSB +: 2];
      end
   end

   // conversion timing: one result per channel period, round robin
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_ff <= ST_IDLE;
         ch_ff <= 2'h0;
         cnt_ff <= 24'h000000;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               cnt_ff <= 24'h000000;
               ch_ff <= 2'h0;
               if (run_ff) begin
                  state_ff <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (!run_ff) begin
                  state_ff <= ST_IDLE;
               end else if (conv_end) begin
                  cnt_ff <= 24'h000000;
                  ch_ff <= ch_next;
               end else if (i_mod_clk_tick) begin
                  cnt_ff <= cnt_ff + 24'h000001;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // results counter: software clear loses no result, the new count wins
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         result_cnt_ff <= 16'h0000;
      end else if (conv_end) begin
         result_cnt_ff <= wr_cnt ? 16'h0001 : result_cnt_ff + 16'h0001;
      end else if (wr_cnt) begin
         result_cnt_ff <= 16'h0000;
      end
   end

   // coefficients from a completed correction run, per channel
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ofs_run_ff <= '0;
         gain_run_ff <= '0;
      end else if (conv_end) begin
         if (ofs_corr) begin
            ofs_run_ff[ch_ff] <= 1'b1;
         end
         if (gain_corr) begin
            gain_run_ff[ch_ff] <= 1'b1;
         end
      end
   end

   // registered outputs
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         path_ff <= '0;
         int_osc_ff <= 1'b1;
         ext_sel_ff <= 1'b0;
         mains_ff <= 1'b0;
         ofs_meas_ff <= 1'b0;
         gain_meas_ff <= 1'b0;
         ofs_src_ff <= 1'b0;
         gain_src_ff <= 1'b0;
         done_ff <= 1'b0;
         done_ch_ff <= 2'h0;
      end else begin
         path_ff <= nxt_path;
         int_osc_ff <= ~external_crystal_use;
         ext_sel_ff <= external_crystal_use;
         mains_ff <= (cur_cfg.rate <= ARC_RATE_MAINS_MAX);
         ofs_meas_ff <= ofs_corr & (state_ff == ST_CONV);
         gain_meas_ff <= gain_corr & (state_ff == ST_CONV);
         ofs_src_ff <= ofs_run_ff[ch_ff];
         gain_src_ff <= gain_run_ff[ch_ff];
         done_ff <= conv_end;
         if (conv_end) begin
            done_ch_ff <= ch_ff;
         end
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_int_osc_en = int_osc_ff;
   assign o_ext_clk_sel = ext_sel_ff;
   assign o_active_ch = done_ch_ff;
   assign o_fixed_stage_on = path_ff.fixed_stage_on;
   assign o_pga_code = path_ff.pga_code;
   assign o_input_buffer_on = path_ff.input_buffer_on;
   assign o_mains_reject = mains_ff;
   assign o_offset_measure = ofs_meas_ff;
   assign o_gain_measure = gain_meas_ff;
   assign o_offset_from_run = ofs_src_ff;
   assign o_gain_from_run = gain_src_ff;
   assign o_conv_done = done_ff;
   assign o_done_ch = done_ch_ff;

   // checks
   AST_GAIN_SPLIT: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      1'b1 |=> (o_fixed_stage_on == $past(cur_cfg.gain[2])) && (o_pga_code == $past(cur_cfg.gain[1:0])))
      else $error("gain split wrong");
   AST_BUF_FORCED: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (cur_cfg.gain >= ARC_GAIN_FIXED_MIN) |=> o_input_buffer_on)
      else $error("buffer not forced at high gain");
   AST_BUF_SELECT: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (cur_cfg.gain < ARC_GAIN_FIXED_MIN) |=> (o_input_buffer_on == $past(cur_cfg.buf_en)))
      else $error("buffer ignores enable bit");
   AST_OSC_OFF: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (detect_ff && i_external_crystal_present) |=> (!o_int_osc_en && o_ext_clk_sel))
      else $error("internal oscillator left on");
   AST_RATE_RST: assert property (@(posedge i_core_clk)
      i_sys_rst |=> (cfg_ff[0].rate == ARC_RATE_RST))
      else $error("reset rate not fastest");
   AST_PERIOD: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (mode_ff == BG_CAL_OFF && cur_cfg.rate[1:0] == 2'h3)
      |-> (cur_period == (cur_cfg.rate[2] ? FAST_DIV : SLOW_DIV)))
      else $error("conversion period wrong");
   AST_SCAN_NEXT: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (conv_end && run_ff) |=> (ch_ff == $past(ch_next)) && o_conv_done)
      else $error("scan did not advance");
   AST_MAINS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (cur_cfg.rate > ARC_RATE_MAINS_MAX) |=> !o_mains_reject)
      else $error("mains flag at fast rate");
   AST_PENALTY: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (mode_ff == OFFSET_GAIN_CORRECT && !fixcal_ff && cur_cfg.rate == 3'h7)
      |-> (cur_period == FAST_DIV + CAL_EXTRA))
      else $error("correction overhead missing");
   AST_EST_KEEP: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      (mode_ff == OFFSET_GAIN_ESTIMATE) |=> $stable(ofs_run_ff) && $stable(gain_run_ff))
      else $error("estimation altered run coefficients");
endmodule : arc_rate_gain_ctrl
`default_nettype wire

// File: testbench/arc_tick_src.sv
`default_nettype none
// converter clock source and crystal sense seen by the block
module arc_tick_src (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // pacing and crystal
   input wire logic [1:0] i_div,
   input wire logic i_external_crystal_on,
   output logic o_tick,
   output logic o_external_crystal_present
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_ff;
   assign o_tick = (cnt_ff == 2'h0);
   assign o_external_crystal_present = i_external_crystal_on;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || cnt_ff >= i_div - 2'h1) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
      end
   end
endmodule : arc_tick_src
`default_nettype wire

// File: testbench/adc_rate_gain_bgcal_control_bench.sv
`default_nettype none
module adc_rate_gain_bgcal_control_bench
   import arc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic rd; logic [31:0] d; logic err;} arc_bus_note_t;
   typedef struct {logic [1:0] ch; int gap;} arc_conv_note_t;
   localparam int SDIV = 64;
   localparam int FDIV = 16;
   localparam int CEXT = 4;
   logic i_core_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, i_mod_clk_tick, i_external_crystal_present, o_int_osc_en, o_ext_clk_sel;
   logic [1:0] o_active_ch, o_pga_code, o_done_ch;
   logic o_fixed_stage_on, o_input_buffer_on, o_mains_reject, o_offset_measure;
   logic o_gain_measure, o_offset_from_run, o_gain_from_run, o_conv_done;
   logic [1:0] tick_div = 2'h1;
   logic external_crystal_on = 1'b0;
   logic [15:0] rnd = 16'heecc;
   logic [31:0] cfg [4];
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   int since = 0;
   int total = 0;
   arc_bus_note_t busq[$];
   arc_conv_note_t convq[$];
   arc_bus_note_t bn;
   arc_conv_note_t cn;

   arc_rate_gain_ctrl #(.SLOW_DIV(24'h000040), .FAST_DIV(24'h000010),
      .CAL_EXTRA(24'h000004), .OFS_EXTRA(24'h000000)) dut_u (.i_core_clk, .i_sys_rst,
      .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .i_mod_clk_tick, .i_external_crystal_present, .o_int_osc_en, .o_ext_clk_sel,
      .o_active_ch, .o_fixed_stage_on, .o_pga_code, .o_input_buffer_on, .o_mains_reject,
      .o_offset_measure, .o_gain_measure, .o_offset_from_run, .o_gain_from_run,
      .o_conv_done, .o_done_ch);
   arc_tick_src src_u (.i_core_clk, .i_sys_rst, .i_div(tick_div), .i_external_crystal_on(external_crystal_on),
      .o_tick(i_mod_clk_tick), .o_external_crystal_present(i_external_crystal_present));

   always #20 i_core_clk = ~i_core_clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic int per(input logic [2:0] r, input logic [1:0] m, input logic fx);
      int p;
      p = (r[2] ? FDIV : SDIV) << (3 - r[1:0]);
      if (m == 2'h2 && !fx) begin
         p = p + CEXT;
      end
      return p;
   endfunction : per

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
      @(posedge i_core_clk);
      busq.push_back('{!wr, exp, err});
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do @(posedge i_core_clk); while (o_pready !== 1'b1);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   // two channels in turn, three rounds, then stop
   task automatic phase(input logic [1:0] m, input logic fx, input logic [1:0] dv);
      int g0, g1, r;
      g0 = per(3'h7, m, fx) * dv;
      g1 = per(3'h3, m, fx) * dv;
      tick_div <= dv;
      for (r = 0; r < 3; r++) begin
         convq.push_back('{2'h0, (r == 0) ? 0 : g0});
         convq.push_back('{2'h1, g1});
      end
      total = total + 6;
      apb(1'b1, ARC_CTRL_OFS, {22'h0, 2'h1, 3'h0, 1'b1, 1'b0, fx, m}, 32'h0, 1'b0);
      repeat (3) @(posedge i_core_clk);
      check({31'h0, o_offset_measure}, {31'h0, m == 2'h1 || m == 2'h2});
      check({31'h0, o_gain_measure}, {31'h0, m == 2'h2});
      if (m == 2'h3) begin
         check({31'h0, o_offset_from_run}, {31'h0, total > 12});
         check({31'h0, o_gain_from_run}, {31'h0, total > 12});
      end
      while (convq.size() != 0) @(posedge i_core_clk);
      apb(1'b1, ARC_CTRL_OFS, {29'h0, fx, m}, 32'h0, 1'b0);
   endtask : phase

   always @(posedge i_core_clk) begin
      if (i_psel && i_penable && o_pready === 1'b1 && busq.size() != 0) begin
         bn = busq.pop_front();
         check({31'h0, o_pslverr}, {31'h0, bn.err});
         if (bn.rd) begin
            check(o_prdata, bn.d);
         end
      end
   end

   always @(posedge i_core_clk) begin
      since = since + 1;
      if (o_conv_done === 1'b1) begin
         if (convq.size() == 0) begin
            failures++;
            $display("wrong value at %0t: result not expected", $time);
         end else begin
            cn = convq.pop_front();
            check({30'h0, o_done_ch}, {30'h0, cn.ch});
            check({30'h0, o_active_ch}, {30'h0, cn.ch});
            if (cn.gap != 0) begin
               check(since, cn.gap);
            end
         end
         since = 0;
      end
   end

   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end

   initial begin
      int i;
      logic [31:0] d;
      logic [2:0] g;
      logic [2:0] rt;
      repeat (5) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_core_clk);
      check({31'h0, o_int_osc_en}, 32'h1);
      apb(1'b0, ARC_CTRL_OFS, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ARC_STAT_OFS, 32'h0, 32'h2, 1'b0);
      apb(1'b0, ARC_CNT_OFS, 32'h0, 32'h0, 1'b0);
      for (i = 0; i < 4; i++) begin
         apb(1'b0, ARC_CHCFG_OFS + 8'(4 * i), 32'h0, 32'h7, 1'b0);
      end
      apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h40, 32'hffffffff, 32'h0, 1'b1);
      for (i = 1; i < 4; i++) begin
         rnd = lfsr(rnd);
         cfg[i] = {rnd, lfsr(rnd)};
         apb(1'b1, ARC_CHCFG_OFS + 8'(4 * i), cfg[i], 32'h0, 1'b0);
      end
      for (i = 1; i < 4; i++) begin
         apb(1'b0, ARC_CHCFG_OFS + 8'(4 * i), 32'h0, cfg[i] & 32'hf7, 1'b0);
      end
      rnd = lfsr(rnd);
      d = {16'h0, rnd} & 32'h0000030f;
      apb(1'b1, ARC_CTRL_OFS, d, 32'h0, 1'b0);
      apb(1'b0, ARC_CTRL_OFS, 32'h0, d, 1'b0);
      apb(1'b1, ARC_CTRL_OFS, 32'h0, 32'h0, 1'b0);
      for (i = 0; i < 16; i++) begin
         g = i[2:0];
         rt = g ^ 3'h5;
         apb(1'b1, ARC_CHCFG_OFS, {24'h0, i[3], g, 1'b0, rt}, 32'h0, 1'b0);
         repeat (2) @(posedge i_core_clk);
         check({31'h0, o_fixed_stage_on}, {31'h0, g[2]});
         check({30'h0, o_pga_code}, {30'h0, g[1:0]});
         check({31'h0, o_input_buffer_on}, {31'h0, g[2] | i[3]});
         check({31'h0, o_mains_reject}, {31'h0, rt <= 3'h3});
      end
      external_crystal_on <= 1'b1;
      apb(1'b1, ARC_CTRL_OFS, 32'h8, 32'h0, 1'b0);
      repeat (3) @(posedge i_core_clk);
      check({30'h0, o_ext_clk_sel, o_int_osc_en}, 32'h2);
      apb(1'b0, ARC_STAT_OFS, 32'h0, 32'h1, 1'b0);
      apb(1'b1, ARC_CTRL_OFS, 32'h0, 32'h0, 1'b0);
      repeat (3) @(posedge i_core_clk);
      check({30'h0, o_ext_clk_sel, o_int_osc_en}, 32'h1);
      external_crystal_on <= 1'b0;
      apb(1'b1, ARC_CHCFG_OFS, 32'h07, 32'h0, 1'b0);
      apb(1'b1, ARC_CHCFG_OFS + 8'h04, 32'h03, 32'h0, 1'b0);
      phase(2'h3, 1'b0, 2'h1);
      phase(2'h0, 1'b0, 2'h1);
      phase(2'h1, 1'b0, 2'h1);
      phase(2'h2, 1'b0, 2'h1);
      phase(2'h2, 1'b1, 2'h2);
      phase(2'h3, 1'b0, 2'h1);
      apb(1'b0, ARC_CNT_OFS, 32'h0, 32'(total), 1'b0);
      apb(1'b1, ARC_CNT_OFS, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ARC_CNT_OFS, 32'h0, 32'h0, 1'b0);
      give_verdict();
   end
endmodule : adc_rate_gain_bgcal_control_bench
`default_nettype wire
